// >>> epi_ext_int.sv
// External interrupt front end: dedicated sources, shared pin group, wake-up requests.
// Assumes an 8-bit register port in the extended register space and raw GPIO pin levels.
`timescale 1ns/1ps

// Function
// - Each group pin has an enable bit; 1 lets it join the group request.
// - Dedicated sources zero, one, two enabled by bits 0, 1, 2.
// - Group polarity bit 6: 1 rising/high wake, 0 falling/low wake.
// - Source two trigger bits 5:4: 01 falling, 10 rising, else both.
// - Source one trigger bits 3:2: 01 falling, 10 rising, else both.
// - Source zero trigger bits 1:0: 01 falling, 10 rising, else both.
// - Low power: dedicated wake on level; rising code wakes high, others low.
// - Enabled group pins OR into one request; one event served at a time.
// - While any enabled group pin is active, other edges do not trigger.
// - Pins need two equal synchronised samples before an edge is seen; no debounce filtering.
module epi_ext_int #(
    parameter int NUM_DED   = epi_pkg::NUM_DED,
    parameter int NUM_GROUP = epi_pkg::NUM_GROUP
) (
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    input  wire logic [15:0]          sfr_addr,
    input  wire logic                 sfr_wr,
    input  wire logic                 sfr_rd,
    input  wire logic [7:0]           sfr_wdata,
    output logic      [7:0]           sfr_rdata,
    input  wire logic [7:0]           group_pin_enable_high,
    input  wire logic                 low_power,
    input  wire logic [NUM_DED-1:0]   dedicated_pin,
    input  wire logic [NUM_GROUP-1:0] group_pin,
    output logic      [NUM_DED-1:0]   dedicated_irq,
    output logic                      group_irq,
    output logic                      wake_req
);
    logic [7:0]                 group_pin_enable_mid;
    logic [7:0]                 group_pin_enable_low;
    logic [NUM_DED-1:0]         dedicated_source_enable;
    epi_pkg::epi_trig_ctrl_t    trigger_polarity_control;
    epi_pkg::epi_trig_mode_t    mode [NUM_DED];
    logic [NUM_DED-1:0]         ded_level;
    logic [NUM_DED-1:0]         ded_rise;
    logic [NUM_DED-1:0]         ded_fall;
    logic [NUM_GROUP-1:0]       grp_level;
    logic [NUM_GROUP-1:0]       group_pin_enable_bit;
    logic [NUM_GROUP-1:0]       grp_active;
    logic                       any_active;
    logic                       any_active_q;
    logic [NUM_DED-1:0]         next_ded_irq;
    logic [NUM_DED-1:0]         ded_wake;

    function automatic epi_pkg::epi_trig_mode_t decode_trig(input logic [1:0] sel);
        epi_pkg::epi_trig_mode_t m;
        m.on_rise   = (sel != epi_pkg::TRIG_FALL);
        m.on_fall   = (sel != epi_pkg::TRIG_RISE);
        m.wake_high = (sel == epi_pkg::TRIG_RISE);
        return m;
    endfunction

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            group_pin_enable_mid     <= epi_pkg::RST_GROUP_EN;
            group_pin_enable_low     <= epi_pkg::RST_GROUP_EN;
            dedicated_source_enable  <= epi_pkg::RST_DED_EN;
            trigger_polarity_control <= epi_pkg::RST_TRIG_CTRL;
        end else if (sfr_wr) begin
            if (sfr_addr == epi_pkg::ADDR_GROUP_EN_MID) begin
                group_pin_enable_mid <= sfr_wdata;
            end else if (sfr_addr == epi_pkg::ADDR_GROUP_EN_LOW) begin
                group_pin_enable_low <= sfr_wdata;
            end else if (sfr_addr == epi_pkg::ADDR_DED_EN) begin
                dedicated_source_enable <= sfr_wdata[NUM_DED-1:0];
            end else if (sfr_addr == epi_pkg::ADDR_TRIG_CTRL) begin
                trigger_polarity_control          <= sfr_wdata;
                trigger_polarity_control.reserved <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sfr_rdata <= epi_pkg::READ_UNMAPPED;
        end else if (sfr_rd) begin
            if (sfr_addr == epi_pkg::ADDR_GROUP_EN_MID) begin
                sfr_rdata <= group_pin_enable_mid;
            end else if (sfr_addr == epi_pkg::ADDR_GROUP_EN_LOW) begin
                sfr_rdata <= group_pin_enable_low;
            end else if (sfr_addr == epi_pkg::ADDR_DED_EN) begin
                sfr_rdata <= {{(8-NUM_DED){1'b0}}, dedicated_source_enable};
            end else if (sfr_addr == epi_pkg::ADDR_TRIG_CTRL) begin
                sfr_rdata <= trigger_polarity_control;
            end else begin
                sfr_rdata <= epi_pkg::READ_UNMAPPED;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin capture
    // ------------------------------------------------------------
    // Synchronisation plus a two-sample agreement check stands before edge detection; no debounce filter.
    epi_pin_sync #(.WIDTH(NUM_DED)) u_ded_sync (
        .core_clk  (core_clk),
        .rst       (rst),
        .pin_async (dedicated_pin),
        .level     (ded_level),
        .rise      (ded_rise),
        .fall      (ded_fall)
    );

    epi_pin_sync #(.WIDTH(NUM_GROUP)) u_grp_sync (
        .core_clk  (core_clk),
        .rst       (rst),
        .pin_async (group_pin),
        .level     (grp_level),
        .rise      (),
        .fall      ()
    );

    // ------------------------------------------------------------
    // Dedicated sources
    // ------------------------------------------------------------
    assign mode[2] = decode_trig(trigger_polarity_control.source_two_trigger_sel);
    assign mode[1] = decode_trig(trigger_polarity_control.source_one_trigger_sel);
    assign mode[0] = decode_trig(trigger_polarity_control.source_zero_trigger_sel);

    always_comb begin
        for (int i = 0; i < NUM_DED; i++) begin
            next_ded_irq[i] = dedicated_source_enable[i] &
                              ((mode[i].on_rise & ded_rise[i]) | (mode[i].on_fall & ded_fall[i]));
            ded_wake[i]     = dedicated_source_enable[i] & (ded_level[i] == mode[i].wake_high);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            dedicated_irq <= '0;
        end else begin
            dedicated_irq <= next_ded_irq;
        end
    end

    // ------------------------------------------------------------
    // Shared pin group
    // ------------------------------------------------------------
    assign group_pin_enable_bit = {group_pin_enable_high, group_pin_enable_mid, group_pin_enable_low};
    assign grp_active = group_pin_enable_bit &
                        (trigger_polarity_control.group_trigger_polarity ? grp_level : ~grp_level);
    // The OR of all active pins is edge-detected, so a second pin cannot fire until all are idle.
    assign any_active = |grp_active;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            any_active_q <= 1'b0;
        end else begin
            any_active_q <= any_active;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            group_irq <= 1'b0;
        end else begin
            group_irq <= any_active & ~any_active_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wake_req <= 1'b0;
        end else begin
            wake_req <= low_power & ((|ded_wake) | any_active);
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    AST_GRP_EN_WRITE: assert property (
        sfr_wr && sfr_addr == epi_pkg::ADDR_GROUP_EN_LOW |=> group_pin_enable_low == $past(sfr_wdata)
    ) else $error("Group enable write not stored.");

    AST_DED_DISABLED: assert property (
        !dedicated_source_enable[0] ##1 !$past(dedicated_source_enable[0], 1) |-> !dedicated_irq[0] || $past(dedicated_source_enable[0], 2)
    ) else $error("Disabled dedicated source raised a request.");

    AST_GRP_POL_RISE: assert property (
        trigger_polarity_control.group_trigger_polarity && group_pin_enable_low[0] && grp_level[0]
        |-> any_active
    ) else $error("Rising polarity high pin not active.");

    AST_SRC2_FALL: assert property (
        dedicated_source_enable[2] && trigger_polarity_control.source_two_trigger_sel == epi_pkg::TRIG_FALL
        && ded_rise[2] && !ded_fall[2] |=> !dedicated_irq[2]
    ) else $error("Source two falling mode fired on rise.");

    AST_SRC1_RISE: assert property (
        dedicated_source_enable[1] && trigger_polarity_control.source_one_trigger_sel == epi_pkg::TRIG_RISE
        && ded_rise[1] |=> dedicated_irq[1]
    ) else $error("Source one rising edge missed.");

    AST_SRC0_BOTH: assert property (
        dedicated_source_enable[0] && trigger_polarity_control.source_zero_trigger_sel == 2'h0
        && (ded_rise[0] || ded_fall[0]) |=> dedicated_irq[0]
    ) else $error("Source zero both-edge missed.");

    AST_WAKE_LEVEL: assert property (
        low_power && dedicated_source_enable[0] && !ded_level[0]
        && trigger_polarity_control.source_zero_trigger_sel != epi_pkg::TRIG_RISE |=> wake_req
    ) else $error("Low level wake missing.");

    AST_GRP_ONE_SHOT: assert property (
        group_irq |=> !group_irq
    ) else $error("Group request longer than one cycle.");

    AST_GRP_LOCK: assert property (
        any_active_q && any_active |=> !group_irq
    ) else $error("Group fired while a pin stayed active.");

    AST_GRP_EDGE: assert property (
        $rose(any_active) |=> group_irq
    ) else $error("Group edge did not raise request.");

    COV_GRP: cover property (group_irq);
    COV_DED_BOTH: cover property (dedicated_irq[0] ##[1:50] dedicated_irq[0]);
    COV_WAKE: cover property (low_power && wake_req);
endmodule // epi_ext_int

// >>> epi_pin_model.sv
// Model of the GPIO lines outside the block, such as keypad buttons.
// Assumes the bench calls its tasks shortly after a rising clock edge.
`timescale 1ns/1ps
module epi_pin_model (
    output logic [epi_pkg::NUM_DED-1:0]   dedicated_pin,
    output logic [epi_pkg::NUM_GROUP-1:0] group_pin
);

    // ------------------------------------------------------------
    // Line levels
    // ------------------------------------------------------------
    // Released buttons leave every line at the pull-up level.
    initial begin
        dedicated_pin = '1;
        group_pin     = '1;
    end

    // Each line holds its level until moved, so the synchroniser sees a steady level.
    task automatic set_ded(input int idx, input logic lvl);
        dedicated_pin[idx] = lvl;
    endtask

    task automatic set_grp(input logic [epi_pkg::NUM_GROUP-1:0] lvl);
        group_pin = lvl;
    endtask

endmodule // epi_pin_model

// >>> epi_pin_sync.sv
// Three-stage pin synchroniser with edge pulses.
// Assumes asynchronous pin inputs and one system clock.
`timescale 1ns/1ps
module epi_pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] pin_async,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] next_level;

    // The stages run through reset, so they hold the real pin levels when it ends.
    always_ff @(posedge core_clk) begin
        meta <= pin_async;
        s2   <= meta;
        s3   <= s2;
    end

    // A change is accepted only once the second and third stages agree.
    always_comb begin
        next_level = level;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2[i] == s3[i]) begin
                next_level[i] = s3[i];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        // Loading the settled stage in reset keeps a false edge from following release.
        if (rst) begin
            level <= s3;
        end else begin
            level <= next_level;
        end
    end

    assign rise = next_level & ~level;
    assign fall = ~next_level & level;
endmodule // epi_pin_sync

// >>> epi_pkg.sv
// Package for the external pin interrupt select block: register map, reset values, trigger codes.
// Assumes byte-wide register access in the extended register space.
package epi_pkg;

    localparam logic [15:0] ADDR_GROUP_EN_MID = 16'h204C;
    localparam logic [15:0] ADDR_GROUP_EN_LOW = 16'h204D;
    localparam logic [15:0] ADDR_DED_EN       = 16'h204E;
    localparam logic [15:0] ADDR_TRIG_CTRL    = 16'h204F;

    localparam logic [7:0]  RST_GROUP_EN      = 8'h00;
    localparam logic [2:0]  RST_DED_EN        = 3'h0;
    localparam logic [7:0]  RST_TRIG_CTRL     = 8'h15;
    localparam logic [7:0]  READ_UNMAPPED     = 8'h00;

    localparam logic [1:0]  TRIG_FALL         = 2'h1;
    localparam logic [1:0]  TRIG_RISE         = 2'h2;

    localparam int          NUM_DED           = 3;
    localparam int          NUM_GROUP         = 24;

    // Layout of the trigger polarity control register, msb first.
    typedef struct packed {
        logic       reserved;
        logic       group_trigger_polarity;
        logic [1:0] source_two_trigger_sel;
        logic [1:0] source_one_trigger_sel;
        logic [1:0] source_zero_trigger_sel;
    } epi_trig_ctrl_t;

    // Decoded behaviour of one dedicated source.
    typedef struct packed {
        logic on_rise;
        logic on_fall;
        logic wake_high;
    } epi_trig_mode_t;

endpackage

// >>> tb_external_pin_interrupt_select.sv
// Self-checking bench for the external pin interrupt front end.
// Assumes epi_pkg, epi_pin_sync, epi_ext_int and epi_pin_model are compiled first.
`timescale 1ns/1ps
module tb_external_pin_interrupt_select;

    typedef struct packed {
        logic [1:0] code;
        logic [1:0] src;
        logic       lvl;
        logic [7:0] exp;
    } epi_row_t;

    logic        core_clk;
    logic        rst;
    logic [15:0] sfr_addr;
    logic        sfr_wr;
    logic        sfr_rd;
    logic [7:0]  sfr_wdata;
    logic [7:0]  group_pin_enable_high;
    logic        low_power;
    logic [7:0]  sfr_rdata;
    logic [2:0]  dedicated_pin;
    logic [23:0] group_pin;
    logic [2:0]  dedicated_irq;
    logic        group_irq;
    logic        wake_req;
    logic [7:0]  t;
    int          errors = 0;
    int          checks = 0;
    int          cycles = 0;
    int          n_ded;
    int          n_grp;
    epi_row_t    rows [10] = '{'{2'h1, 2'h0, 1'b0, 8'h01}, '{2'h1, 2'h0, 1'b1, 8'h00},
                             '{2'h2, 2'h1, 1'b1, 8'h01}, '{2'h2, 2'h1, 1'b0, 8'h00},
                             '{2'h0, 2'h2, 1'b1, 8'h01}, '{2'h0, 2'h2, 1'b0, 8'h01},
                             '{2'h3, 2'h0, 1'b1, 8'h01}, '{2'h3, 2'h0, 1'b0, 8'h01},
                             '{2'h1, 2'h2, 1'b1, 8'h00}, '{2'h0, 2'h0, 1'b0, 8'h01}};

    epi_ext_int i_dut (
        .core_clk              (core_clk),
        .rst                   (rst),
        .sfr_addr              (sfr_addr),
        .sfr_wr                (sfr_wr),
        .sfr_rd                (sfr_rd),
        .sfr_wdata             (sfr_wdata),
        .sfr_rdata             (sfr_rdata),
        .group_pin_enable_high (group_pin_enable_high),
        .low_power             (low_power),
        .dedicated_pin         (dedicated_pin),
        .group_pin             (group_pin),
        .dedicated_irq         (dedicated_irq),
        .group_irq             (group_irq),
        .wake_req              (wake_req)
    );

    epi_pin_model i_pins (
        .dedicated_pin (dedicated_pin),
        .group_pin     (group_pin)
    );

    // ------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ------------------------------------------------------------
    always #5 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        sfr_addr  = a;
        sfr_wdata = d;
        sfr_wr    = 1'b1;
        @(posedge core_clk);
        #1 sfr_wr = 1'b0;
        @(posedge core_clk);
        #1;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
        sfr_addr = a;
        sfr_rd   = 1'b1;
        @(posedge core_clk);
        #1 sfr_rd = 1'b0;
        chk(what, exp, sfr_rdata);
        @(posedge core_clk);
        #1;
    endtask

    // Counts request pulses over a window longer than the synchroniser latency.
    task automatic watch(input int src);
        n_ded = 0;
        n_grp = 0;
        repeat (8) begin
            @(posedge core_clk);
            #1;
            n_ded += (dedicated_irq[src] === 1'b0) ? 0 : 1;
            n_grp += (group_irq === 1'b0) ? 0 : 1;
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        core_clk              = 1'b0;
        rst                   = 1'b1;
        sfr_addr              = 16'h0000;
        sfr_wr                = 1'b0;
        sfr_rd                = 1'b0;
        sfr_wdata             = 8'h00;
        group_pin_enable_high = 8'h00;
        low_power             = 1'b0;
        repeat (10) @(posedge core_clk);
        #1 rst = 1'b0;
        rd(epi_pkg::ADDR_GROUP_EN_MID, 8'h00, "group_pin_enable_mid");
        rd(epi_pkg::ADDR_GROUP_EN_LOW, 8'h00, "group_pin_enable_low");
        rd(epi_pkg::ADDR_DED_EN, 8'h00, "dedicated_source_enable");
        rd(epi_pkg::ADDR_TRIG_CTRL, 8'h15, "trigger_polarity_control");
        rd(16'h2050, 8'h00, "unmapped");
        wr(epi_pkg::ADDR_DED_EN, 8'hFF);
        rd(epi_pkg::ADDR_DED_EN, 8'h07, "dedicated_source_enable");
        wr(epi_pkg::ADDR_TRIG_CTRL, 8'hFF);
        rd(epi_pkg::ADDR_TRIG_CTRL, 8'h7F, "trigger_polarity_control");
        foreach (rows[i]) begin
            t = 8'h15 & ~(8'h03 << (2 * rows[i].src)) | ({6'h00, rows[i].code} << (2 * rows[i].src));
            wr(epi_pkg::ADDR_TRIG_CTRL, t);
            wr(epi_pkg::ADDR_DED_EN, 8'h01 << rows[i].src);
            i_pins.set_ded(rows[i].src, !rows[i].lvl);
            watch(0);
            i_pins.set_ded(rows[i].src, rows[i].lvl);
            watch(rows[i].src);
            chk("dedicated_irq", rows[i].exp, 8'(n_ded));
        end
        wr(epi_pkg::ADDR_DED_EN, 8'h00);
        i_pins.set_ded(0, 1'b1);
        watch(0);
        chk("dedicated_irq disabled", 8'h00, 8'(n_ded));
        low_power = 1'b1;
        wr(epi_pkg::ADDR_TRIG_CTRL, 8'h16);
        wr(epi_pkg::ADDR_DED_EN, 8'h01);
        watch(0);
        chk("wake_req high level", 8'h01, {7'h00, wake_req});
        i_pins.set_ded(0, 1'b0);
        watch(0);
        chk("wake_req low level", 8'h00, {7'h00, wake_req});
        wr(epi_pkg::ADDR_TRIG_CTRL, 8'h15);
        watch(0);
        chk("wake_req falling code", 8'h01, {7'h00, wake_req});
        low_power = 1'b0;
        wr(epi_pkg::ADDR_DED_EN, 8'h00);
        wr(epi_pkg::ADDR_GROUP_EN_LOW, 8'h01);
        wr(epi_pkg::ADDR_GROUP_EN_MID, 8'h02);
        rd(epi_pkg::ADDR_GROUP_EN_MID, 8'h02, "group_pin_enable_mid");
        rd(epi_pkg::ADDR_GROUP_EN_LOW, 8'h01, "group_pin_enable_low");
        watch(0);
        i_pins.set_grp(24'hFFFFFE);
        watch(0);
        chk("group_irq pin0", 8'h01, 8'(n_grp));
        i_pins.set_grp(24'hFFFDFE);
        watch(0);
        chk("group_irq blocked", 8'h00, 8'(n_grp));
        i_pins.set_grp(24'hFFFFFF);
        watch(0);
        chk("group_irq release", 8'h00, 8'(n_grp));
        i_pins.set_grp(24'hFFFDFF);
        watch(0);
        chk("group_irq pin9", 8'h01, 8'(n_grp));
        i_pins.set_grp(24'hFFFFFF);
        watch(0);
        i_pins.set_grp(24'hFFFFDF);
        watch(0);
        chk("group_irq masked", 8'h00, 8'(n_grp));
        group_pin_enable_high = 8'h10;
        i_pins.set_grp(24'hFFFFFF);
        watch(0);
        i_pins.set_grp(24'hEFFFFF);
        watch(0);
        chk("group_irq pin20", 8'h01, 8'(n_grp));
        i_pins.set_grp(24'h000000);
        wr(epi_pkg::ADDR_TRIG_CTRL, 8'h55);
        watch(0);
        i_pins.set_grp(24'h000001);
        watch(0);
        chk("group_irq rising", 8'h01, 8'(n_grp));
        low_power = 1'b1;
        watch(0);
        chk("wake_req group high", 8'h01, {7'h00, wake_req});
        i_pins.set_grp(24'h000000);
        watch(0);
        chk("wake_req group idle", 8'h00, {7'h00, wake_req});
        rst = 1'b1;
        repeat (4) @(posedge core_clk);
        #1 rst = 1'b0;
        chk("outputs after reset", 8'h00, {3'h0, dedicated_irq, group_irq, wake_req});
        chk("sfr_rdata after reset", 8'h00, sfr_rdata);
        rd(epi_pkg::ADDR_TRIG_CTRL, 8'h15, "trigger_polarity_control after reset");
        complete_run();
    end

endmodule // tb_external_pin_interrupt_select
